// ==== src/hfp_pkg.sv ====
// Constants and types for the half-bridge fault protection block
// Summary of operation
// RULE_01 - Supply undervoltage: all outputs off, set fail flag
// RULE_02 - Undervoltage recovery restores outputs, clears fail flag
// RULE_03 - Settings accepted during undervoltage, applied on recovery
// RULE_04 - Overvoltage with lockout set: outputs off, flag
// RULE_05 - Overvoltage recovery restores outputs, clears fail flag
// RULE_06 - Settings accepted during overvoltage, applied after recovery
// RULE_07 - Lockout setting clear: outputs stay on, flag set
// RULE_08 - Host should keep overvoltage lockout set
// RULE_09 - Persistent overcurrent after delay latches channel off
// RULE_10 - Overcurrent shutdown sets channel code 01
// RULE_11 - Overcurrent code wins over other channel faults
// RULE_12 - Status reset clears overcurrent, re-enables channels
// RULE_13 - Any underload starts one shared delay timer
// RULE_14 - Later underload gets only the remaining time
// RULE_15 - Persistent underload with shutdown set: latch off, code 10
// RULE_16 - Underload shutdown setting clear keeps drivers on
// RULE_17 - Status reset clears underload flag and codes
// RULE_18 - Thermal warning follows sensor, outputs unaffected
// RULE_19 - Thermal shutdown latches channel off, frame bit 15
// RULE_20 - Status reset clears thermal shutdown once cooled
// RULE_21 - Shutdown flag on serial output before first clock
// RULE_22 - Host holds clock and input low before select
// RULE_23 - Host spaces status resets by the reset interval
// RULE_24 - Status frozen during frame, published after select rises
// RULE_25 - Delays are parameters, detector inputs are synchronised
package hfp_pkg;
   localparam int NUM_CH = 6;
   localparam int FRAME_BITS = 16;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OC_DELAY_NS = 10000;
   localparam int UL_DELAY_NS = 200000;
   localparam int OC_DELAY_CYC = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UL_DELAY_CYC = (UL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
   localparam logic [CNT_W-1:0] FRAME_CNT_MAX = 5'h1f;
   localparam int BIT_TSHUT = 15;
   localparam int BIT_OC = 14;
   localparam int BIT_UL = 13;
   localparam int BIT_SUPPLY = 12;
   localparam int BIT_WARN = 11;
   localparam int BIT_RESET_REQ = 15;
   localparam int PAD_BITS = 11;
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_OVERCURRENT = 2'h1;
   localparam logic [1:0] CODE_UNDERLOAD = 2'h2;
   localparam logic [1:0] CODE_THERMAL = 2'h3;
   typedef enum logic {
      UL_IDLE = 1'b0,
      UL_RUN = 1'b1
   } hfp_ul_state_t;
endpackage

// ==== src/hfp_fault_ctrl.sv ====
// Fault supervision, shutdown latching and serial status link for six half-bridges
`timescale 1ns/1ps
module hfp_fault_ctrl #(
   parameter int OC_DELAY_CYC_P = hfp_pkg::OC_DELAY_CYC,
   parameter int UL_DELAY_CYC_P = hfp_pkg::UL_DELAY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [hfp_pkg::NUM_CH-1:0] overcurrent_det_i,
   input wire logic [hfp_pkg::NUM_CH-1:0] underload_det_i,
   input wire logic [hfp_pkg::NUM_CH-1:0] warn_det_i,
   input wire logic [hfp_pkg::NUM_CH-1:0] tshut_det_i,
   input wire logic [1:0] supply_uv_det_i,
   input wire logic [1:0] supply_ov_det_i,
   input wire logic overvoltage_lockout_setting_i,
   input wire logic underload_shutdown_setting_i,
   input wire logic [hfp_pkg::NUM_CH-1:0] channel_output_enable_i,
   input wire logic [hfp_pkg::NUM_CH-1:0] channel_side_select_i,
   input wire logic serial_clk_i,
   input wire logic chip_select_low_i,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic nserial_out_oe_o,
   output logic [hfp_pkg::NUM_CH-1:0] high_side_on_o,
   output logic [hfp_pkg::NUM_CH-1:0] low_side_on_o,
   output logic supply_fail_flag_o,
   output logic overcurrent_flag_o,
   output logic underload_flag_o,
   output logic thermal_warning_flag_o,
   output logic thermal_shutdown_flag_o,
   output logic [2*hfp_pkg::NUM_CH-1:0] channel_fault_code_o
);
   import hfp_pkg::*;

   localparam int OC_W = $clog2(OC_DELAY_CYC_P + 1);
   localparam int UL_W = $clog2(UL_DELAY_CYC_P + 1);
   localparam logic [OC_W-1:0] OC_LAST = OC_W'(OC_DELAY_CYC_P - 1);
   localparam logic [UL_W-1:0] UL_LAST = UL_W'(UL_DELAY_CYC_P - 1);
   localparam int RAW_W = 4 * NUM_CH + 5;
   // Select rests high, so its stages reset to that level and no false frame end follows reset
   localparam logic [RAW_W-1:0] SYNC_IDLE = {1'b1, {(RAW_W-1){1'b0}}};

   function automatic logic [1:0] fault_code(input logic oc, input logic ul, input logic th);
      if (oc) begin
         fault_code = CODE_OVERCURRENT;
      end else if (ul) begin
         fault_code = CODE_UNDERLOAD;
      end else if (th) begin
         fault_code = CODE_THERMAL;
      end else begin
         fault_code = CODE_NONE;
      end
   endfunction

   // Two-stage synchroniser for every asynchronous detector and the select pin
   logic [RAW_W-1:0] raw_in;
   logic [RAW_W-1:0] sync_meta;
   logic [RAW_W-1:0] sync_q;
   assign raw_in = {chip_select_low_i, supply_ov_det_i, supply_uv_det_i, tshut_det_i,
                    warn_det_i, underload_det_i, overcurrent_det_i};

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_meta <= SYNC_IDLE;
         sync_q <= SYNC_IDLE;
      end else begin
         sync_meta <= raw_in; // [RULE_25]
         sync_q <= sync_meta;
      end
   end

   logic [NUM_CH-1:0] oc_s;
   logic [NUM_CH-1:0] ul_s;
   logic [NUM_CH-1:0] warn_s;
   logic [NUM_CH-1:0] tshut_s;
   logic [1:0] uv_s;
   logic [1:0] ov_s;
   logic cs_low_s;
   assign oc_s = sync_q[NUM_CH-1:0];
   assign ul_s = sync_q[2*NUM_CH-1:NUM_CH];
   assign warn_s = sync_q[3*NUM_CH-1:2*NUM_CH];
   assign tshut_s = sync_q[4*NUM_CH-1:3*NUM_CH];
   assign uv_s = sync_q[4*NUM_CH+1:4*NUM_CH];
   assign ov_s = sync_q[4*NUM_CH+3:4*NUM_CH+2];
   assign cs_low_s = sync_q[4*NUM_CH+4];

   // Link-side receive logic on the serial clock
   logic [FRAME_BITS-1:0] rx_shift;
   logic [CNT_W-1:0] bit_cnt;
   logic tx_bit;
   logic [FRAME_BITS-1:0] status_word;

   always_ff @(posedge serial_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_shift <= '0;
      end else begin
         rx_shift <= {rx_shift[FRAME_BITS-2:0], serial_in_i};
      end
   end

   // Select high clears the count between frames
   always_ff @(posedge serial_clk_i or posedge chip_select_low_i) begin
      if (chip_select_low_i) begin
         bit_cnt <= '0;
      end else if (bit_cnt != FRAME_CNT_MAX) begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   always_ff @(negedge serial_clk_i or posedge chip_select_low_i) begin
      if (chip_select_low_i) begin
         tx_bit <= 1'b0;
      end else if (bit_cnt < FRAME_LEN) begin
         tx_bit <= status_word[BIT_TSHUT - int'(bit_cnt)];
      end else begin
         tx_bit <= 1'b0;
      end
   end

   // Shutdown flag appears as soon as select falls, before any clock edge
   assign serial_out_o = (bit_cnt == '0) ? status_word[BIT_TSHUT] : tx_bit; // [RULE_21]
   assign nserial_out_oe_o = chip_select_low_i;

   // Frame verdict caught at the select rising edge; the same edge clears the count afterwards
   logic frame_req;
   always_ff @(posedge chip_select_low_i or negedge nrst_i) begin
      if (!nrst_i) begin
         frame_req <= 1'b0;
      end else begin
         frame_req <= (bit_cnt == FRAME_LEN) && rx_shift[BIT_RESET_REQ]; // [RULE_12] [RULE_17] [RULE_20]
      end
   end

   logic cs_low_d;
   logic reset_req;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cs_low_d <= 1'b1;
      end else begin
         cs_low_d <= cs_low_s;
      end
   end
   // Verdict has stood for two system edges when synchronised select rises, so it is read as is
   assign reset_req = cs_low_s && !cs_low_d && frame_req;

   // Supply supervision
   logic uv_any;
   logic ov_any;
   logic lockout;
   logic supply_fail;
   assign uv_any = |uv_s;
   assign ov_any = |ov_s;
   assign lockout = uv_any || (ov_any && overvoltage_lockout_setting_i); // [RULE_01] [RULE_04] [RULE_07]
   assign supply_fail = uv_any || ov_any; // [RULE_02] [RULE_05]

   // Shared underload delay timer
   hfp_ul_state_t ul_state;
   logic [UL_W-1:0] ul_cnt;
   logic ul_any;
   logic ul_expire;
   assign ul_any = |ul_s;
   assign ul_expire = (ul_state == UL_RUN) && ul_any && (ul_cnt == UL_LAST); // [RULE_14]

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ul_state <= UL_IDLE;
         ul_cnt <= '0;
      end else begin
         unique case (ul_state)
            UL_IDLE: begin
               ul_cnt <= '0;
               if (ul_any) begin
                  ul_state <= UL_RUN; // [RULE_13]
               end
            end
            UL_RUN: begin
               if (!ul_any || ul_expire) begin
                  ul_state <= UL_IDLE;
                  ul_cnt <= '0;
               end else begin
                  ul_cnt <= ul_cnt + UL_W'(1);
               end
            end
         endcase
      end
   end

   // Per-channel delay, latching and drive
   logic [NUM_CH-1:0] oc_shut;
   logic [NUM_CH-1:0] ul_code;
   logic [NUM_CH-1:0] ul_shut;
   logic [NUM_CH-1:0] th_shut;
   logic [NUM_CH-1:0] oc_set;
   logic [2*NUM_CH-1:0] code_live;
   logic [OC_W-1:0] oc_cnt [NUM_CH];

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         assign oc_set[ch] = oc_s[ch] && (oc_cnt[ch] == OC_LAST);

         always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               oc_cnt[ch] <= '0;
            end else if (!oc_s[ch]) begin
               oc_cnt[ch] <= '0;
            end else if (oc_cnt[ch] != OC_LAST) begin
               oc_cnt[ch] <= oc_cnt[ch] + OC_W'(1); // [RULE_09]
            end
         end

         // Set wins over a status reset in the same cycle
         always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               oc_shut[ch] <= 1'b0;
            end else if (oc_set[ch]) begin
               oc_shut[ch] <= 1'b1; // [RULE_09]
            end else if (reset_req) begin
               oc_shut[ch] <= 1'b0; // [RULE_12]
            end
         end

         always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               ul_code[ch] <= 1'b0;
               ul_shut[ch] <= 1'b0;
            end else if (ul_expire && ul_s[ch]) begin
               ul_code[ch] <= 1'b1;
               ul_shut[ch] <= ul_shut[ch] || underload_shutdown_setting_i; // [RULE_15] [RULE_16]
            end else if (reset_req) begin
               ul_code[ch] <= 1'b0; // [RULE_17]
               ul_shut[ch] <= 1'b0;
            end
         end

         // A still-hot sensor wins over a status reset in the same cycle, so reset only frees a cooled channel
         always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               th_shut[ch] <= 1'b0;
            end else if (tshut_s[ch]) begin
               th_shut[ch] <= 1'b1; // [RULE_19]
            end else if (reset_req) begin
               th_shut[ch] <= 1'b0; // [RULE_20]
            end
         end

         assign code_live[2*ch+1:2*ch] = fault_code(oc_shut[ch], ul_code[ch], th_shut[ch]); // [RULE_10] [RULE_11]

         // Settings are live ports; lockout only masks them, so new values apply on recovery
         always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               high_side_on_o[ch] <= 1'b0;
               low_side_on_o[ch] <= 1'b0;
            end else begin
               high_side_on_o[ch] <= channel_output_enable_i[ch] && channel_side_select_i[ch] && !lockout
                                     && !oc_shut[ch] && !ul_shut[ch] && !th_shut[ch]; // [RULE_03] [RULE_06]
               low_side_on_o[ch] <= channel_output_enable_i[ch] && !channel_side_select_i[ch] && !lockout
                                    && !oc_shut[ch] && !ul_shut[ch] && !th_shut[ch]; // [RULE_02] [RULE_05]
            end
         end
      end
   endgenerate

   // Global sticky flags
   logic oc_flag;
   logic ul_flag;
   logic th_flag;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oc_flag <= 1'b0;
      end else if (|oc_set) begin
         oc_flag <= 1'b1; // [RULE_09]
      end else if (reset_req) begin
         oc_flag <= 1'b0; // [RULE_12]
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ul_flag <= 1'b0;
      end else if (ul_expire) begin
         ul_flag <= 1'b1; // [RULE_15]
      end else if (reset_req) begin
         ul_flag <= 1'b0; // [RULE_17]
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         th_flag <= 1'b0;
      end else if (|tshut_s) begin
         th_flag <= 1'b1; // [RULE_19]
      end else if (reset_req) begin
         th_flag <= 1'b0; // [RULE_20]
      end
   end

   // Published status, held while a frame is open
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         supply_fail_flag_o <= 1'b0;
         overcurrent_flag_o <= 1'b0;
         underload_flag_o <= 1'b0;
         thermal_warning_flag_o <= 1'b0;
         thermal_shutdown_flag_o <= 1'b0;
         channel_fault_code_o <= '0;
      end else if (cs_low_s && cs_low_d) begin // [RULE_24]
         supply_fail_flag_o <= supply_fail; // [RULE_01]
         overcurrent_flag_o <= oc_flag;
         underload_flag_o <= ul_flag;
         thermal_warning_flag_o <= (|warn_s) || (|tshut_s); // [RULE_18]
         thermal_shutdown_flag_o <= th_flag;
         channel_fault_code_o <= code_live;
      end
   end

   assign status_word = {thermal_shutdown_flag_o, overcurrent_flag_o, underload_flag_o,
                         supply_fail_flag_o, thermal_warning_flag_o, PAD_BITS'(0)}; // [RULE_19]

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_uv_outputs_off: assert property (uv_any |=> (high_side_on_o == '0) && (low_side_on_o == '0)) // [RULE_01]
      else $error("outputs still on during undervoltage");
   a_ov_lock_off: assert property ((ov_any && overvoltage_lockout_setting_i) // [RULE_04]
                                   |=> (high_side_on_o == '0) && (low_side_on_o == '0))
      else $error("outputs still on during overvoltage lockout");
   a_ov_no_lock: assert property ((ov_any && !uv_any && !overvoltage_lockout_setting_i
                                   && channel_output_enable_i[0] && !oc_shut[0] && !ul_shut[0] && !th_shut[0])
                                  |=> (high_side_on_o[0] || low_side_on_o[0])) // [RULE_07]
      else $error("channel dropped during overvoltage without lockout");
   a_supply_recover: assert property ((!lockout && channel_output_enable_i[0] && channel_side_select_i[0]
                                       && !oc_shut[0] && !ul_shut[0] && !th_shut[0]) |=> high_side_on_o[0]) // [RULE_02]
      else $error("channel not restored after supply recovery");
   a_fail_flag_pub: assert property ((cs_low_s && cs_low_d && supply_fail) |=> supply_fail_flag_o) // [RULE_05]
      else $error("supply fail flag not published");
   a_oc_timer_latch: assert property ((oc_s[0] && oc_cnt[0] == OC_LAST) |=> oc_shut[0] && oc_flag) // [RULE_09]
      else $error("overcurrent not latched at delay expiry");
   a_oc_code_first: assert property (oc_shut[0] |-> code_live[1:0] == CODE_OVERCURRENT) // [RULE_11]
      else $error("overcurrent code not reported first");
   a_reset_clears_oc: assert property ((reset_req && !oc_set[0]) |=> !oc_shut[0]) // [RULE_12]
      else $error("status reset did not clear overcurrent latch");
   a_ul_no_shutdown: assert property ((!underload_shutdown_setting_i && !ul_shut[0]) |=> !ul_shut[0]) // [RULE_16]
      else $error("underload shut channel with shutdown setting clear");
   a_th_shut_off: assert property (th_shut[0] |=> !high_side_on_o[0] && !low_side_on_o[0]) // [RULE_19]
      else $error("thermal shutdown left channel driving");
   a_status_frozen: assert property ((!cs_low_s && !cs_low_d) |=> $stable(channel_fault_code_o)
                                     && $stable(thermal_shutdown_flag_o)) // [RULE_24]
      else $error("status changed during a frame");

   a_oc_code_pub: assert property ((cs_low_s && cs_low_d && oc_shut[0]) // [RULE_10]
                                   |=> channel_fault_code_o[1:0] == CODE_OVERCURRENT)
      else $error("overcurrent code not published");
   a_oc_short_pulse: assert property (!oc_s[0] |=> oc_cnt[0] == '0) // [RULE_09]
      else $error("overcurrent timer kept counting after input dropped");
   a_ul_latch_on: assert property ((ul_expire && ul_s[0] && underload_shutdown_setting_i) // [RULE_15]
                                   |=> ul_shut[0] && ul_flag)
      else $error("underload did not latch channel off");
   a_ul_code_set: assert property ((ul_expire && ul_s[0]) |=> ul_code[0] && ul_flag) // [RULE_15]
      else $error("underload code not set at timer expiry");
   a_reset_clears_ul: assert property ((reset_req && !ul_expire) // [RULE_17]
                                       |=> !ul_shut[0] && !ul_code[0] && !ul_flag)
      else $error("status reset did not clear underload");
   a_ul_idle_clear: assert property ((ul_state == UL_RUN && !ul_any) // [RULE_13]
                                     |=> ul_state == UL_IDLE && ul_cnt == '0)
      else $error("underload timer kept running without underload");
   a_th_warn_held: assert property ((cs_low_s && cs_low_d && tshut_s[0]) |=> thermal_warning_flag_o) // [RULE_19]
      else $error("warning flag not held during thermal shutdown");
   a_th_reset_clear: assert property ((reset_req && !tshut_s[0]) |=> !th_shut[0]) // [RULE_20]
      else $error("status reset did not free a cooled channel");

   c_oc_shutdown: cover property ($rose(oc_shut[0]));
   c_ul_shutdown: cover property ($rose(ul_shut[0]));
   c_status_reset: cover property (reset_req && (oc_flag || ul_flag || th_flag));
   c_ov_no_lock: cover property (ov_any && !overvoltage_lockout_setting_i && (|high_side_on_o));
   c_th_shutdown: cover property ($rose(th_shut[0]));
endmodule // hfp_fault_ctrl

// ==== sim/hfp_spi_host.sv ====
// Serial host model that runs status frames against the fault controller
`timescale 1ns/1ps
module hfp_spi_host #(
   parameter int HALF_NS = 3,
   parameter int SETUP_NS = 5,
   parameter int RESET_GAP_NS = 200
) (
   input wire logic serial_out_i,
   input wire logic nserial_out_oe_i,
   output logic serial_clk_o,
   output logic chip_select_low_o,
   output logic serial_in_o
);
   initial begin
      serial_clk_o = 1'b0;
      chip_select_low_o = 1'b1;
      serial_in_o = 1'b0;
   end

   // Clock stands low outside frames; data line rests at its pull-down level
   task automatic frame(input logic [15:0] tx, input int nbits, input int slow, output logic [15:0] rx,
         output logic first);
      int h;
      h = HALF_NS * slow;
      rx = 16'h0;
      serial_clk_o = 1'b0;
      serial_in_o = 1'b0;
      #(h);
      chip_select_low_o = 1'b0;
      #(SETUP_NS);
      first = (nserial_out_oe_i === 1'b0) ? serial_out_i : 1'bx;
      for (int i = 0; i < nbits; i++) begin
         serial_in_o = tx[15-i];
         #(h);
         rx[15-i] = serial_out_i;
         serial_clk_o = 1'b1;
         #(h);
         serial_clk_o = 1'b0;
      end
      #(h);
      serial_in_o = 1'b0;
      chip_select_low_o = 1'b1;
      if (tx[15]) begin
         #(RESET_GAP_NS);
      end
   endtask
endmodule // hfp_spi_host

// ==== sim/hfp_fault_ctrl_tb.sv ====
// Self-checking bench for the half-bridge fault controller
`timescale 1ns/1ps
module hfp_fault_ctrl_tb;
   import hfp_pkg::*;
   localparam int OC_CYC = 8;
   localparam int UL_CYC = 20;
   logic sys_clk_i, nrst_i, ovl, uls, lock, first;
   logic [NUM_CH-1:0] oc_det, ul_det, warn_det, tsd_det, en, sel, off, hs, ls;
   logic [1:0] uv_det, ov_det;
   logic sclk, csn, sdi, sdo, sdo_oe_n;
   logic f_sup, f_oc, f_ul, f_warn, f_tsd;
   logic [2*NUM_CH-1:0] codes, exp_codes;
   logic [4:0] exp_flags;
   logic [15:0] rx;
   logic [31:0] seed;
   logic [28:0] exp_q[$];
   int n_fail, samples_checked;

   hfp_fault_ctrl #(.OC_DELAY_CYC_P(OC_CYC), .UL_DELAY_CYC_P(UL_CYC)) uut (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .overcurrent_det_i(oc_det), .underload_det_i(ul_det),
      .warn_det_i(warn_det), .tshut_det_i(tsd_det), .supply_uv_det_i(uv_det), .supply_ov_det_i(ov_det),
      .overvoltage_lockout_setting_i(ovl), .underload_shutdown_setting_i(uls),
      .channel_output_enable_i(en), .channel_side_select_i(sel), .serial_clk_i(sclk),
      .chip_select_low_i(csn), .serial_in_i(sdi), .serial_out_o(sdo), .nserial_out_oe_o(sdo_oe_n),
      .high_side_on_o(hs), .low_side_on_o(ls), .supply_fail_flag_o(f_sup), .overcurrent_flag_o(f_oc),
      .underload_flag_o(f_ul), .thermal_warning_flag_o(f_warn), .thermal_shutdown_flag_o(f_tsd),
      .channel_fault_code_o(codes));

   hfp_spi_host host (.serial_out_i(sdo), .nserial_out_oe_i(sdo_oe_n), .serial_clk_o(sclk),
      .chip_select_low_o(csn), .serial_in_o(sdi));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction

   // Flags held as {supply, overcurrent, underload, warning, shutdown}
   function automatic logic [15:0] frm();
      return {exp_flags[0], exp_flags[3], exp_flags[2], exp_flags[4], exp_flags[1], 11'h0};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   // Expected driver commands follow enable and side select unless locked or latched off
   task automatic note();
      exp_q.push_back({lock ? 12'h0 : {en & sel & ~off, en & ~sel & ~off}, exp_flags, exp_codes});
   endtask

   task automatic xfer(input logic [15:0] tx, input int nbits, input int slow);
      host.frame(tx, nbits, slow, rx, first);
      cyc(8);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      #200000;
      n_fail++;
      finish_test();
   end

   // Compares each queued note against the settled outputs
   initial forever begin
      @(negedge sys_clk_i);
      #1;
      while (exp_q.size() > 0) check({hs, ls, f_sup, f_oc, f_ul, f_warn, f_tsd, codes}, exp_q.pop_front());
   end

   initial begin
      nrst_i = 1'b0;
      ovl = 1'b1;
      uls = 1'b1;
      {oc_det, ul_det, warn_det, tsd_det, uv_det, ov_det} = '0;
      {off, lock, exp_flags, exp_codes} = '0;
      seed = 32'hc6b7dcf1;
      en = '1;
      sel = seed[5:0];
      n_fail = 0;
      samples_checked = 0;
      cyc(3);
      nrst_i = 1'b1;
      cyc(6);
      note();
      // Undervoltage, overvoltage with lockout, overvoltage without lockout
      for (int k = 0; k < 3; k++) begin
         ovl = (k != 2);
         if (k == 0) begin
            uv_det = 2'h1;
         end else begin
            ov_det = {k == 1, k == 2};
         end
         lock = (k != 2);
         exp_flags[4] = 1'b1;
         cyc(6);
         note();
         seed = lfsr(seed);
         {en, sel} = seed[11:0];
         cyc(6);
         note();
         {uv_det, ov_det} = '0;
         {lock, exp_flags[4]} = '0;
         cyc(6);
         note();
      end
      ovl = 1'b1;
      // Supply fault inside a slow frame stays unpublished until select rises
      fork
         xfer(16'h0, 16, 20);
         begin
            cyc(20);
            uv_det = 2'h2;
            lock = 1'b1;
            cyc(8);
            note();
         end
      join
      check(rx, 16'h0);
      exp_flags[4] = 1'b1;
      note();
      uv_det = '0;
      {lock, exp_flags[4]} = '0;
      en = '1;
      warn_det = 6'h10;
      cyc(6);
      exp_flags[1] = 1'b1;
      note();
      warn_det = '0;
      oc_det = 6'h04;
      cyc(4);
      oc_det = '0;
      cyc(OC_CYC + 6);
      exp_flags[1] = 1'b0;
      note();
      // Overcurrent and thermal shutdown together on one channel
      {oc_det[2], tsd_det[2], warn_det[2]} = 3'h7;
      cyc(OC_CYC + 8);
      off[2] = 1'b1;
      exp_flags = 5'h0b;
      exp_codes[5:4] = CODE_OVERCURRENT;
      note();
      xfer(16'h0, 16, 1);
      check(first, 1'b1);
      check(rx, frm());
      oc_det = '0;
      xfer(16'h8000, 16, 1);
      exp_flags = 5'h03;
      exp_codes[5:4] = CODE_THERMAL;
      note();
      {tsd_det, warn_det} = '0;
      xfer(16'h8000, 15, 1);
      exp_flags = 5'h01;
      note();
      xfer(16'h8000, 16, 1);
      {off, exp_flags, exp_codes} = '0;
      note();
      // Shared underload timer, with and without shutdown
      for (int k = 1; k >= 0; k--) begin
         uls = k[0];
         ul_det[0] = 1'b1;
         cyc(12);
         ul_det[3] = 1'b1;
         cyc(UL_CYC - 6);
         exp_flags[2] = 1'b1;
         exp_codes = {4'h0, CODE_UNDERLOAD, 4'h0, CODE_UNDERLOAD};
         off = uls ? 6'h09 : 6'h00;
         note();
         ul_det = '0;
         xfer(16'h8000, 16, 1);
         {off, exp_flags, exp_codes} = '0;
         note();
      end
      cyc(4);
      finish_test();
   end
endmodule // hfp_fault_ctrl_tb
